// *** design/dbeep_top.sv ***
// Purpose: Compressor attack and decay stepping plus programmable tone generator
// Assumes: One pulse on dac_sample_strobe per DAC word clock
// Notes: Registers reached through a plain byte port at their documented offsets
//
// What this block does
// - The attack field steps gain by 4 dB per sample at code 0, halving for each higher code.
// - The decay field steps gain by 0.015625 dB per sample divided by two to the field value.
// - Setting the enable bit starts the tone, clearing it stops it, and it clears itself when the count runs out.
// - The 6-bit volume code gives 2 dB at code 0 and 1 dB less for each step up to -61 dB.
// - A tone is produced only when the DAC path runs the one tone-capable processing block.
// - Bits 23 to 16 of the 24-bit sample count have their own byte register.
// - Bits 15 to 8 of the sample count have a separate byte register written on its own.
// - Bits 7 to 0 of the sample count sit in a third byte register.
// - Tone frequency is set by 16-bit sine and cosine coefficients, each over two byte registers.
`timescale 1ns/1ps
`default_nettype none
`include "dbeep_defs.svh"

module dbeep_top
	import dbeep_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire dbeep_req_type req,
	output logic [7:0] reg_rdata,
	input wire logic dac_sample_strobe,
	input wire logic [4:0] tone_capable_processing_block,
	input wire logic signed [31:0] dynamic_range_compressor_target_gain,
	output logic signed [31:0] dynamic_range_compressor_gain,
	output logic signed [15:0] tone_sample,
	output logic tone_active
);

	////////////////////////////////////////////////////////////////////////////////
	// State and oscillator
	// The oscillator keeps its own state so a restart never disturbs the registers

	dbeep_state_type q;
	dbeep_state_type d;
	logic osc_start;
	logic osc_step;
	logic signed [15:0] osc_y;
	logic capable;
	logic [3:0] vol_shift;
	logic [2:0] vol_frac;
	logic signed [15:0] vol_mant;
	logic signed [31:0] scaled_full;
	logic signed [31:0] scaled;
	logic signed [31:0] attack_step;
	logic signed [31:0] decay_step;
	logic signed [31:0] gap;

	dbeep_tone_osc u_osc (
		.ref_clk(ref_clk),
		.srst(srst),
		.start(osc_start),
		.step(osc_step),
		.sin_coef({q.regs.sin_high, q.regs.sin_low}),
		.cos_coef({q.regs.cos_high, q.regs.cos_low}),
		.sample(osc_y)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Volume: whole 6 dB steps are shifts, the rest a small mantissa table
	// Arithmetic shift truncates toward minus infinity, under one LSB of error at any code

	always_comb
	begin
		vol_shift = 4'(q.regs.tone_ctrl[5:0] / 6'(`DBEEP_VOL_DB_PER_OCT));
		vol_frac = 3'(q.regs.tone_ctrl[5:0] % 6'(`DBEEP_VOL_DB_PER_OCT));
		unique case (vol_frac)
			3'h0: vol_mant = 16'sh5092;
			3'h1: vol_mant = 16'sh47cf;
			3'h2: vol_mant = 16'sh4000;
			3'h3: vol_mant = 16'sh390a;
			3'h4: vol_mant = 16'sh32d6;
			3'h5: vol_mant = 16'sh2d4f;
			default: vol_mant = 16'sh0000;
		endcase
		scaled_full = osc_y * vol_mant;
		scaled = scaled_full >>> (`DBEEP_VOL_FRAC + 32'(vol_shift));
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		d = q;
		osc_start = 1'b0;
		osc_step = 1'b0;
		capable = tone_capable_processing_block == `DBEEP_TONE_BLOCK;
		attack_step = 32'sh1 <<< (`DBEEP_ATTACK_TOP_SHIFT - 32'(q.regs.rate[7:4]));
		decay_step = 32'sh1 <<< (`DBEEP_DECAY_TOP_SHIFT - 32'(q.regs.rate[3:0]));
		// Gain is dB with 21 fraction bits, so both steps are single-bit shifts
		gap = dynamic_range_compressor_target_gain - q.gain;

		// Compressor gain walks toward its target once per sample
		if (dac_sample_strobe)
		begin
			// Clamping to the target stops the gain hunting around it
			if (gap < 0)
				d.gain = (-gap < attack_step) ? q.gain + gap : q.gain - attack_step;
			else if (gap > 0)
				d.gain = (gap < decay_step) ? q.gain + gap : q.gain + decay_step;
		end

		// Tone: counts only while the capable block runs; outside it, silence and the count holds
		if (q.mode == dbeep_run && dac_sample_strobe)
		begin
			// A paused tone keeps its phase and resumes where it stopped
			if (!capable)
				d.tone = 16'sh0000;
			else if (q.remain == 24'h000000)
			begin
				d.regs.tone_ctrl[`DBEEP_BIT_TONE_EN] = 1'b0;
				d.mode = dbeep_idle;
				d.tone = 16'sh0000;
			end
			else
			begin
				d.remain = q.remain - 24'h000001;
				osc_step = 1'b1;
				// Saturate rather than wrap: a wrapped sample is a loud click
				if (scaled > 32'sh00007fff)
					d.tone = 16'sh7fff;
				else if (scaled < -32'sh00008000)
					d.tone = -16'sh8000;
				else
					d.tone = scaled[15:0];
			end
		end

		// Software writes come last so a write in the self-clear cycle wins
		if (req.wr)
		begin
			unique case (req.addr)
				`DBEEP_OFF_RATE: d.regs.rate = req.wdata;
				`DBEEP_OFF_TONE_CTRL:
				begin
					// Reserved bit is stored as written and steers nothing
					d.regs.tone_ctrl = req.wdata;
					if (req.wdata[`DBEEP_BIT_TONE_EN])
					begin
						d.mode = dbeep_run;
						// Length bytes are taken at enable; later writes apply to the next tone
						d.remain = {q.regs.len_high, q.regs.len_mid, q.regs.len_low};
						d.tone = 16'sh0000;
						osc_start = 1'b1;
					end
					else
					begin
						d.mode = dbeep_idle;
						d.tone = 16'sh0000;
					end
				end
				`DBEEP_OFF_RSVD: d.regs.rsvd = req.wdata;
				`DBEEP_OFF_LEN_HIGH: d.regs.len_high = req.wdata;
				`DBEEP_OFF_LEN_MID: d.regs.len_mid = req.wdata;
				`DBEEP_OFF_LEN_LOW: d.regs.len_low = req.wdata;
				`DBEEP_OFF_SIN_HIGH: d.regs.sin_high = req.wdata;
				`DBEEP_OFF_SIN_LOW: d.regs.sin_low = req.wdata;
				`DBEEP_OFF_COS_HIGH: d.regs.cos_high = req.wdata;
				`DBEEP_OFF_COS_LOW: d.regs.cos_low = req.wdata;
				// Offsets outside the map are ignored
				default: ;
			endcase
		end

		// Read data is registered; the enable bit shows the live self-clearing state
		if (req.rd)
		begin
			unique case (req.addr)
				`DBEEP_OFF_RATE: d.rdata = q.regs.rate;
				`DBEEP_OFF_TONE_CTRL: d.rdata = q.regs.tone_ctrl;
				`DBEEP_OFF_RSVD: d.rdata = q.regs.rsvd;
				`DBEEP_OFF_LEN_HIGH: d.rdata = q.regs.len_high;
				`DBEEP_OFF_LEN_MID: d.rdata = q.regs.len_mid;
				`DBEEP_OFF_LEN_LOW: d.rdata = q.regs.len_low;
				`DBEEP_OFF_SIN_HIGH: d.rdata = q.regs.sin_high;
				`DBEEP_OFF_SIN_LOW: d.rdata = q.regs.sin_low;
				`DBEEP_OFF_COS_HIGH: d.rdata = q.regs.cos_high;
				`DBEEP_OFF_COS_LOW: d.rdata = q.regs.cos_low;
				default: d.rdata = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			q <= '0;
			// Coefficients reset to a usable tone, so setting the enable bit alone beeps
			q.regs.rate <= `DBEEP_RST_RATE;
			q.regs.tone_ctrl <= `DBEEP_RST_TONE_CTRL;
			q.regs.rsvd <= `DBEEP_RST_RSVD;
			q.regs.len_high <= `DBEEP_RST_LEN_HIGH;
			q.regs.len_mid <= `DBEEP_RST_LEN_MID;
			q.regs.len_low <= `DBEEP_RST_LEN_LOW;
			q.regs.sin_high <= `DBEEP_RST_SIN_HIGH;
			q.regs.sin_low <= `DBEEP_RST_SIN_LOW;
			q.regs.cos_high <= `DBEEP_RST_COS_HIGH;
			q.regs.cos_low <= `DBEEP_RST_COS_LOW;
			q.mode <= dbeep_idle;
		end
		else
			q <= d;
	end

	assign reg_rdata = q.rdata;
	assign dynamic_range_compressor_gain = q.gain;
	assign tone_sample = q.tone;
	// Active means running, even while a block without tone support pauses it
	assign tone_active = q.mode == dbeep_run;

endmodule : dbeep_top
`default_nettype wire

// *** design/dbeep_defs.svh ***
// Purpose: Offsets, reset values, field positions and timing figures of the compressor rate and tone block
// Assumes: Byte-wide registers on the documented control port
// Notes: Definitions only
`ifndef DBEEP_DEFS_SVH
`define DBEEP_DEFS_SVH

`define DBEEP_OFF_RATE 8'h46
`define DBEEP_OFF_TONE_CTRL 8'h47
`define DBEEP_OFF_RSVD 8'h48
`define DBEEP_OFF_LEN_HIGH 8'h49
`define DBEEP_OFF_LEN_MID 8'h4a
`define DBEEP_OFF_LEN_LOW 8'h4b
`define DBEEP_OFF_SIN_HIGH 8'h4c
`define DBEEP_OFF_SIN_LOW 8'h4d
`define DBEEP_OFF_COS_HIGH 8'h4e
`define DBEEP_OFF_COS_LOW 8'h4f

`define DBEEP_RST_RATE 8'h00
`define DBEEP_RST_TONE_CTRL 8'h00
`define DBEEP_RST_RSVD 8'h00
`define DBEEP_RST_LEN_HIGH 8'h00
`define DBEEP_RST_LEN_MID 8'h00
`define DBEEP_RST_LEN_LOW 8'hee
`define DBEEP_RST_SIN_HIGH 8'h10
`define DBEEP_RST_SIN_LOW 8'hd8
`define DBEEP_RST_COS_HIGH 8'h7e
`define DBEEP_RST_COS_LOW 8'he3

`define DBEEP_BIT_TONE_EN 7
`define DBEEP_BIT_TONE_RSVD 6

// Gain is signed dB with this many fraction bits
`define DBEEP_GAIN_FRAC 21
// 4 dB = 2^2, base decay 0.015625 dB = 2^-6, as shifts of one LSB
`define DBEEP_ATTACK_TOP_SHIFT 23
`define DBEEP_DECAY_TOP_SHIFT 15

`define DBEEP_TONE_BLOCK 5'h19
`define DBEEP_OSC_ONE 16'sh7fff
`define DBEEP_OSC_FRAC 15
`define DBEEP_VOL_FRAC 14
`define DBEEP_VOL_DB_PER_OCT 6

`endif

// *** design/dbeep_pkg.sv ***
// Purpose: Types of the compressor rate and tone block
// Assumes: Constants live in dbeep_defs.svh
// Notes: State structs hold all flops of each module
package dbeep_pkg;

	typedef enum logic {dbeep_idle, dbeep_run} dbeep_mode_type;

	typedef struct packed {
		logic [7:0] rate;
		logic [7:0] tone_ctrl;
		logic [7:0] rsvd;
		logic [7:0] len_high;
		logic [7:0] len_mid;
		logic [7:0] len_low;
		logic [7:0] sin_high;
		logic [7:0] sin_low;
		logic [7:0] cos_high;
		logic [7:0] cos_low;
	} dbeep_regs_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dbeep_req_type;

	typedef struct packed {
		dbeep_regs_type regs;
		dbeep_mode_type mode;
		logic [23:0] remain;
		logic signed [31:0] gain;
		logic signed [15:0] tone;
		logic [7:0] rdata;
	} dbeep_state_type;

	typedef struct packed {
		logic signed [15:0] x;
		logic signed [15:0] y;
	} dbeep_osc_type;

endpackage : dbeep_pkg

// *** design/dbeep_tone_osc.sv ***
// Purpose: Recursive sinusoid oscillator, one step per DAC sample
// Assumes: Coefficients in signed Q1.15
// Notes: Rotation form keeps amplitude near full scale
`timescale 1ns/1ps
`default_nettype none
`include "dbeep_defs.svh"

module dbeep_tone_osc
	import dbeep_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic start,
	input wire logic step,
	input wire logic signed [15:0] sin_coef,
	input wire logic signed [15:0] cos_coef,
	output logic signed [15:0] sample
);

	dbeep_osc_type q;
	dbeep_osc_type d;
	logic signed [32:0] nx;
	logic signed [32:0] ny;

	always_comb
	begin
		d = q;
		nx = 33'(cos_coef * q.x) - 33'(sin_coef * q.y);
		ny = 33'(sin_coef * q.x) + 33'(cos_coef * q.y);
		if (start)
		begin
			d.x = `DBEEP_OSC_ONE;
			d.y = 16'sh0000;
		end
		else if (step)
		begin
			d.x = nx[30:15];
			d.y = ny[30:15];
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			q <= '0;
		else
			q <= d;
	end

	assign sample = q.y;

endmodule : dbeep_tone_osc
`default_nettype wire

// *** verification/dbeep_top_checker.sv ***
// Purpose: Port assertions for dbeep_top
// Assumes: One clock, srst synchronous
// Notes: Watches ports only, inputs and outputs, no internal state
`timescale 1ns/1ps
`default_nettype none
module dbeep_top_checker
	import dbeep_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire dbeep_req_type req,
	input wire logic [7:0] reg_rdata,
	input wire logic dac_sample_strobe,
	input wire logic [4:0] tone_capable_processing_block,
	input wire logic signed [31:0] dynamic_range_compressor_target_gain,
	input wire logic signed [31:0] dynamic_range_compressor_gain,
	input wire logic signed [15:0] tone_sample,
	input wire logic tone_active
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	wire logic st = dac_sample_strobe;
	wire logic w47 = req.wr && req.addr == 8'h47;
	wire logic signed [31:0] gn = dynamic_range_compressor_gain;
	wire logic signed [31:0] tg = dynamic_range_compressor_target_gain;
	////////////////////////////////////////////////////////////////
	property p_gain_hold; !st |=> $stable(gn); endproperty
	a_gain_hold: assert property (p_gain_hold) else $error("gain moved");
	property p_attack; st && gn > tg |=>
		gn < $past(gn) && gn >= $past(tg); endproperty
	a_attack: assert property (p_attack) else $error("bad attack");
	property p_decay; st && gn < tg |=>
		gn > $past(gn) && gn <= $past(tg); endproperty
	a_decay: assert property (p_decay) else $error("bad decay");
	// Largest steps are 4 dB down and 0.015625 dB up
	property p_step_max; st |=> $past(gn) - gn <= 32'sh800000 &&
		gn - $past(gn) <= 32'sh8000; endproperty
	a_step_max: assert property (p_step_max) else $error("step too big");
	// Only a strobe or a control write may end a running tone
	property p_keep; tone_active && !st && !w47 |=> tone_active; endproperty
	a_keep: assert property (p_keep) else $error("tone stopped unasked");
	property p_blocked; st && tone_capable_processing_block != 5'h19 |=> tone_sample == 16'sh0; endproperty
	a_blocked: assert property (p_blocked) else $error("tone while blocked");
	property p_stop; w47 && !req.wdata[7] |=> !tone_active && tone_sample == 16'sh0; endproperty
	a_stop: assert property (p_stop) else $error("no stop");
	property p_start; w47 && req.wdata[7] |=> tone_active; endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_sample_hold; !st && !req.wr |=> $stable(tone_sample); endproperty
	a_sample_hold: assert property (p_sample_hold) else $error("sample moved");
	c_down: cover property (st && gn > tg);
	c_up: cover property (st && gn < tg);
	c_end: cover property ($fell(tone_active));
endmodule : dbeep_top_checker
bind dbeep_top dbeep_top_checker u_chk (.ref_clk, .srst, .req, .reg_rdata, .dac_sample_strobe,
	.tone_capable_processing_block, .dynamic_range_compressor_target_gain, .dynamic_range_compressor_gain,
	.tone_sample, .tone_active);
`default_nettype wire

// *** verification/dbeep_top_test.sv ***
// Purpose: Random and corner tests of dbeep_top
// Assumes: Strobes spaced by idle cycles
// Notes: Seeded once, so runs repeat
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module dbeep_top_test
	import dbeep_pkg::*;
;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	dbeep_req_type req = '0;
	logic strb = 1'b0;
	logic [4:0] blk = 5'h00;
	logic signed [31:0] tgt = 32'sh0;
	logic [7:0] reg_rdata;
	logic signed [31:0] dynamic_range_compressor_gain;
	logic signed [15:0] tone_sample;
	logic tone_active;
	logic signed [31:0] g = 32'sh0;
	logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hee, 8'h10, 8'hd8, 8'h7e, 8'he3};
	logic [7:0] d;
	int n_errors = 0;
	int n_compared = 0;
	int n;
	int k;
	dbeep_top u_dut (.ref_clk, .srst, .req, .reg_rdata, .dac_sample_strobe(strb),
		.tone_capable_processing_block(blk), .dynamic_range_compressor_target_gain(tgt),
		.dynamic_range_compressor_gain, .tone_sample, .tone_active);
	initial
	begin
		forever #2 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk) req <= {1'b1, 1'b0, a, v};
		@(posedge ref_clk) req <= '0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk) req <= {1'b0, 1'b1, a, 8'h00};
		@(posedge ref_clk) req <= '0;
		#1;
		`CHK(reg_rdata, e)
	endtask : rd
	task automatic pulse;
		@(posedge ref_clk) strb <= 1'b1;
		@(posedge ref_clk) strb <= 1'b0;
		#1;
	endtask : pulse
	function automatic logic signed [31:0] stp(input int sh);
		return 32'sh1 <<< sh;
	endfunction : stp
	// Quarter-rate tone: sample k is full scale times sin(k quarter turns), scaled by (2 - v) dB
	function automatic logic tone_near(input logic signed [15:0] got, input int k, input int v, input int tol);
		real a;
		int e;
		a = 32767.0 * $pow(10.0, (2.0 - v) / 20.0);
		case (k % 4)
			1: e = int'(a);
			3: e = -int'(a);
			default: e = 0;
		endcase
		return (got - e <= tol) && (e - got <= tol);
	endfunction : tone_near
	// Target one and a half steps away: one full step, then a clamp
	task automatic ramp(input logic signed [31:0] s);
		logic signed [31:0] t;
		t = g + s + (s >>> 1);
		@(posedge ref_clk) tgt <= t;
		pulse;
		`CHK(dynamic_range_compressor_gain, g + s)
		pulse;
		`CHK(dynamic_range_compressor_gain, t)
		g = t;
	endtask : ramp
	task automatic close_out;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'he109));
		repeat (6) @(posedge ref_clk);
		srst <= 1'b0;
		for (int i = 0; i < 10; i++)
			rd(8'h46 + i[7:0], rv[i]);
		rd(8'h50, 8'h00);
		for (int i = 0; i < 10; i++)
		begin
			if (i == 1)
				continue;
			d = 8'($urandom);
			wr(8'h46 + i[7:0], d);
			rd(8'h46 + i[7:0], d);
		end
		wr(8'h50, d);
		rd(8'h50, 8'h00);
		for (int c = 0; c < 16; c++)
		begin
			wr(8'h46, {c[3:0], c[3:0]});
			ramp(-stp(23 - c));
			ramp(stp(15 - c));
		end
		n = $urandom_range(7, 0);
		wr(8'h49, 8'h00);
		wr(8'h4a, 8'h01);
		wr(8'h4b, n[7:0]);
		wr(8'h4c, 8'h7f);
		wr(8'h4d, 8'hff);
		wr(8'h4e, 8'h00);
		wr(8'h4f, 8'h00);
		@(posedge ref_clk) blk <= 5'h19;
		wr(8'h47, 8'h82);
		`CHK(tone_active, 1'b1)
		k = 0;
		repeat (256 + n)
		begin
			pulse;
			`CHK(tone_active, 1'b1)
			`CHK(tone_near(tone_sample, k, 2, 4 + 3 * k), 1'b1)
			k++;
		end
		pulse;
		`CHK(tone_active, 1'b0)
		rd(8'h47, 8'h02);
		wr(8'h4a, 8'h00);
		wr(8'h4b, 8'h04);
		wr(8'h47, 8'hbf);
		k = 0;
		repeat (4)
		begin
			pulse;
			`CHK(tone_sample <= 16'sd32 && tone_sample >= -16'sd32, 1'b1)
			`CHK(tone_near(tone_sample, k, 63, 2), 1'b1)
			k++;
		end
		@(posedge ref_clk) blk <= 5'h18;
		repeat (3)
		begin
			pulse;
			`CHK({tone_active, tone_sample}, 17'h10000)
		end
		wr(8'h47, 8'h3f);
		`CHK({tone_active, tone_sample}, 17'h00000)
		// Reset after the tone is stopped must bring back every reset value and a zero gain
		@(posedge ref_clk) srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		#1;
		`CHK(dynamic_range_compressor_gain, 32'sh0)
		for (int i = 0; i < 10; i++)
			rd(8'h46 + i[7:0], rv[i]);
		close_out;
	end
	// Whole run is under a thousand cycles
	initial
	begin
		#200000;
		n_errors++;
		close_out;
	end
endmodule : dbeep_top_test
`default_nettype wire
